// ==== logic/rxf_pkg.sv ====
// Constants, register map and carrier types of the radio receive FIFO block.
// Assumes one 8-bit register port driven by the on-chip controller core.
package rxf_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int RXF_DEPTH = 64;
  localparam int RXF_AW = 4;
  localparam int RXF_DW = 8;
  localparam int RXF_SEL_W = 6;
  localparam int RXF_PINS = 2;
  localparam int RXF_IRQ_W = 4;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] RXF_REG_PKT_CTRL_FIRST = 4'h0;
  localparam logic [3:0] RXF_REG_PKT_CTRL_SECOND = 4'h1;
  localparam logic [3:0] RXF_REG_PKT_LEN = 4'h2;
  localparam logic [3:0] RXF_REG_PIN_CFG0 = 4'h3;
  localparam logic [3:0] RXF_REG_PIN_CFG2 = 4'h4;
  localparam logic [3:0] RXF_REG_SYNTH_CAL_ONE = 4'h5;
  localparam logic [3:0] RXF_REG_SYNTH_CAL_TWO = 4'h6;
  localparam logic [3:0] RXF_REG_TEST = 4'h7;
  localparam logic [3:0] RXF_REG_COMMAND = 4'h8;
  localparam logic [3:0] RXF_REG_FIFO_DATA = 4'h9;
  localparam logic [3:0] RXF_REG_OCCUPANCY = 4'hA;
  localparam logic [3:0] RXF_REG_PKT_STATUS = 4'hB;
  localparam logic [3:0] RXF_REG_IRQ_STATUS = 4'hC;
  localparam logic [3:0] RXF_REG_IRQ_MASK = 4'hD;
  localparam logic [3:0] RXF_REG_STATE = 4'hE;

  // ****************************************
  // Fields, codes and reset values
  // ****************************************
  localparam int RXF_LEN_CFG_LSB = 0;
  localparam logic [1:0] RXF_LEN_VARIABLE = 2'h1;
  localparam logic [1:0] RXF_LEN_FIXED = 2'h0;
  localparam int RXF_BIT_CRC_EN = 2;
  localparam int RXF_BIT_APPEND = 2;
  localparam int RXF_BIT_OSC_SEL_CAL = 1;
  localparam int RXF_BIT_OSC_CORE_HIGH = 5;
  localparam int RXF_CMD_IDLE = 0;
  localparam int RXF_CMD_RX = 1;
  localparam int RXF_CMD_FLUSH = 2;
  localparam int RXF_CMD_SLEEP = 3;
  localparam int RXF_IRQ_LOCK = 0;
  localparam int RXF_IRQ_OVF = 1;
  localparam int RXF_IRQ_STUCK = 2;
  localparam int RXF_IRQ_PKT = 3;
  localparam int RXF_PST_PIN0 = 0;
  localparam int RXF_PST_PIN2 = 2;
  localparam int RXF_OCC_PF_BIT = 7;
  localparam int RXF_CAL_LOCK_MSB = 5;
  localparam logic [5:0] RXF_SEL_LOCK = 6'h0A;
  localparam logic [5:0] RXF_SEL_PKT_BUSY = 6'h06;
  localparam logic [5:0] RXF_CAL_UNLOCKED = 6'h3F;
  localparam logic [7:0] RXF_CTRL_FIRST_RST = 8'h05;
  localparam logic [7:0] RXF_CTRL_SECOND_RST = 8'h04;
  localparam logic [7:0] RXF_PKT_LEN_RST = 8'hFF;
  localparam logic [5:0] RXF_CAL_ONE_RST = 6'h20;
  localparam logic [7:0] RXF_CAL_TWO_RST = 8'h0A;
  localparam logic [7:0] RXF_TEST_RST = 8'h02;
  localparam logic [7:0] RXF_TEST_SLEEP = 8'h00;
  localparam logic [1:0] RXF_STATUS_BYTES = 2'h2;

  typedef enum logic [2:0] {
    RXF_IDLE, RXF_RX, RXF_STUCK, RXF_OVERFLOW, RXF_SLEEP
  } rxf_radio_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rxf_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic [7:0] rssi;
    logic [6:0] lqi;
    logic crcOk;
  } rxf_rx_in_type;

endpackage : rxf_pkg

// ==== logic/rxf_fifo_mem.sv ====
// Byte store of the receive FIFO: one write port, one read port.
// Assumes the caller never writes the word it reads in the same cycle.
`timescale 1ns/1ps
module rxf_fifo_mem #(
  parameter int W = 8,
  parameter int DEPTH = 64,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : rxf_fifo_mem

// ==== logic/rxf_rx_fifo.sv ====
// Receive FIFO, prefetch byte, status bytes, radio state and lock status.
// Assumes synchronous inputs on ref_clk and a controller using the register port.
`timescale 1ns/1ps
module rxf_rx_fifo
  import rxf_pkg::*;
#(
  parameter int DEPTH = rxf_pkg::RXF_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire rxf_pkg::rxf_reg_req_type regReq,
  output logic [rxf_pkg::RXF_DW-1:0] regRdata,
  // Demodulator side
  input wire rxf_pkg::rxf_rx_in_type rxIn,
  input wire logic lockDet,
  // Status pins and interrupt
  output logic [rxf_pkg::RXF_PINS-1:0] statusPin,
  output logic irq
);
  import rxf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rxf_radio_type state;
    logic [7:0] ctrlFirst;
    logic [7:0] ctrlSecond;
    logic [7:0] packet_length_reg;
    logic [RXF_PINS-1:0][RXF_SEL_W-1:0] sel;
    logic [5:0] calOne;
    logic [7:0] calTwo;
    logic [7:0] testReg;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic pfValid;
    logic [7:0] pfData;
    logic [1:0] stCnt;
    logic [7:0] st0;
    logic [7:0] st1;
    logic lenPend;
    logic [7:0] pktRem;
    logic busy;
    logic lockPrev;
    logic [RXF_IRQ_W-1:0] irqSt;
    logic [RXF_IRQ_W-1:0] irqMask;
    logic [RXF_PINS-1:0] pins;
    logic irq;
    logic [7:0] rdReg;
    logic rdFifo;
  } rxf_state_type;

  localparam rxf_state_type ST_RST = '{
    state: RXF_IDLE,
    ctrlFirst: RXF_CTRL_FIRST_RST,
    ctrlSecond: RXF_CTRL_SECOND_RST,
    packet_length_reg: RXF_PKT_LEN_RST,
    calOne: RXF_CAL_ONE_RST,
    calTwo: RXF_CAL_TWO_RST,
    testReg: RXF_TEST_RST,
    default: '0
  };

  rxf_state_type s_r;
  rxf_state_type s_nxt;
  logic [7:0] memQ;
  logic wrHit;
  logic cmdIdle;
  logic cmdRx;
  logic cmdFlush;
  logic cmdSleep;
  logic varMode;
  logic crcEn;
  logic appendEn;
  logic stuckCombo;
  logic popFifo;
  logic pfMove;
  logic pfFree;
  logic rxTake;
  logic ovfHit;
  logic ovfEv;
  logic stuckEv;
  logic stMove;
  logic lockRise;
  logic pktEnd;

  // ****************************************
  // Decode
  // ****************************************
  assign wrHit = regReq.wr && regReq.addr == RXF_REG_COMMAND;
  assign cmdIdle = wrHit && regReq.wdata[RXF_CMD_IDLE];
  assign cmdRx = wrHit && regReq.wdata[RXF_CMD_RX];
  assign cmdFlush = wrHit && regReq.wdata[RXF_CMD_FLUSH];
  assign cmdSleep = wrHit && regReq.wdata[RXF_CMD_SLEEP];
  assign varMode = s_r.ctrlFirst[RXF_LEN_CFG_LSB +: 2] == RXF_LEN_VARIABLE;
  assign crcEn = s_r.ctrlFirst[RXF_BIT_CRC_EN];
  assign appendEn = s_r.ctrlSecond[RXF_BIT_APPEND];
  // Both trailers enabled is the setting that hangs the receiver on overflow.
  assign stuckCombo = crcEn && appendEn;
  assign popFifo = regReq.rd && regReq.addr == RXF_REG_FIFO_DATA && s_r.count != '0
                   && s_r.state != RXF_SLEEP;
  assign pfMove = s_r.pfValid && s_r.count < CW'(DEPTH);
  assign pfFree = !s_r.pfValid || pfMove;
  assign rxTake = rxIn.valid && s_r.state == RXF_RX;
  assign ovfHit = rxTake && !pfFree;
  assign ovfEv = s_r.state == RXF_RX && !cmdIdle && ovfHit && !stuckCombo;
  assign stuckEv = s_r.state == RXF_RX && !cmdIdle && ovfHit && stuckCombo;
  assign stMove = !rxTake && s_r.stCnt != '0 && pfFree && s_r.state == RXF_RX;
  assign lockRise = lockDet && !s_r.lockPrev;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_nxt = s_r;
    pktEnd = 1'b0;
    s_nxt.lockPrev = lockDet;
    // FIFO pointers; prefetch only moves while a word is free.
    if (pfMove) begin
      s_nxt.wrPtr = s_r.wrPtr + PW'(1);
      s_nxt.pfValid = 1'b0;
    end
    if (popFifo) begin
      s_nxt.rdPtr = s_r.rdPtr + PW'(1);
    end
    s_nxt.count = s_r.count + CW'(pfMove) - CW'(popFifo);
    // Received bytes win the prefetch over pending status bytes.
    if (rxTake && pfFree) begin
      s_nxt.pfValid = 1'b1;
      s_nxt.pfData = rxIn.data;
      s_nxt.busy = 1'b1;
      if (s_r.lenPend) begin
        s_nxt.lenPend = 1'b0;
        s_nxt.pktRem = rxIn.data;
        pktEnd = rxIn.data == 8'h00;
      end else begin
        s_nxt.pktRem = s_r.pktRem - 8'h01;
        pktEnd = s_r.pktRem == 8'h01;
      end
    end else if (stMove) begin
      s_nxt.pfValid = 1'b1;
      s_nxt.pfData = s_r.st0;
      s_nxt.st0 = s_r.st1;
      s_nxt.stCnt = s_r.stCnt - 2'h1;
    end
    if (pktEnd) begin
      s_nxt.busy = 1'b0;
      s_nxt.lenPend = varMode;
      s_nxt.pktRem = s_r.packet_length_reg;
      if (appendEn) begin
        s_nxt.stCnt = RXF_STATUS_BYTES;
        s_nxt.st0 = rxIn.rssi;
        s_nxt.st1 = {crcEn && rxIn.crcOk, rxIn.lqi};
      end
    end
    // Register writes.
    if (regReq.wr) begin
      if (regReq.addr == RXF_REG_PKT_CTRL_FIRST) begin
        s_nxt.ctrlFirst = regReq.wdata;
      end else if (regReq.addr == RXF_REG_PKT_CTRL_SECOND) begin
        s_nxt.ctrlSecond = regReq.wdata;
      end else if (regReq.addr == RXF_REG_PKT_LEN) begin
        s_nxt.packet_length_reg = regReq.wdata;
      end else if (regReq.addr == RXF_REG_PIN_CFG0) begin
        s_nxt.sel[0] = regReq.wdata[RXF_SEL_W-1:0];
      end else if (regReq.addr == RXF_REG_PIN_CFG2) begin
        s_nxt.sel[1] = regReq.wdata[RXF_SEL_W-1:0];
      end else if (regReq.addr == RXF_REG_SYNTH_CAL_ONE) begin
        s_nxt.calOne = regReq.wdata[5:0];
      end else if (regReq.addr == RXF_REG_SYNTH_CAL_TWO) begin
        s_nxt.calTwo = regReq.wdata;
      end else if (regReq.addr == RXF_REG_TEST && s_r.state != RXF_SLEEP) begin
        s_nxt.testReg = regReq.wdata;
      end else if (regReq.addr == RXF_REG_IRQ_MASK) begin
        s_nxt.irqMask = regReq.wdata[RXF_IRQ_W-1:0];
      end
    end
    // Radio state; flush and idle act only in the states listed here.
    case (s_r.state)
      RXF_IDLE: begin
        if (cmdSleep) begin
          s_nxt.state = RXF_SLEEP;
          s_nxt.testReg = RXF_TEST_SLEEP;
        end else if (cmdRx) begin
          s_nxt.state = RXF_RX;
          s_nxt.lenPend = varMode;
          s_nxt.pktRem = s_r.packet_length_reg;
          s_nxt.busy = 1'b0;
        end
      end
      RXF_RX: begin
        if (cmdIdle) begin
          s_nxt.state = RXF_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.stCnt = '0;
        end else if (ovfHit && stuckCombo) begin
          s_nxt.state = RXF_STUCK;
        end else if (ovfHit) begin
          s_nxt.state = RXF_OVERFLOW;
          s_nxt.busy = 1'b0;
        end
      end
      RXF_STUCK: begin
        // A flush alone is ignored here; only idle releases the receiver.
        if (cmdIdle) begin
          s_nxt.state = RXF_IDLE;
          s_nxt.busy = 1'b0;
        end
      end
      RXF_OVERFLOW: begin
        if (cmdFlush) begin
          s_nxt.state = RXF_IDLE;
        end
      end
      RXF_SLEEP: begin
        if (cmdIdle) begin
          s_nxt.state = RXF_IDLE;
        end
      end
      default: begin
        s_nxt.state = RXF_IDLE;
      end
    endcase
    if (cmdFlush && (s_r.state == RXF_IDLE || s_r.state == RXF_OVERFLOW)) begin
      s_nxt.wrPtr = '0;
      s_nxt.rdPtr = '0;
      s_nxt.count = '0;
      s_nxt.pfValid = 1'b0;
      s_nxt.stCnt = '0;
      s_nxt.busy = 1'b0;
    end
    // Sticky events; a set in the clearing cycle survives.
    s_nxt.irqSt = s_r.irqSt;
    if (regReq.wr && regReq.addr == RXF_REG_IRQ_STATUS) begin
      s_nxt.irqSt = s_r.irqSt & ~regReq.wdata[RXF_IRQ_W-1:0];
    end
    s_nxt.irqSt[RXF_IRQ_LOCK] = s_nxt.irqSt[RXF_IRQ_LOCK] | lockRise;
    s_nxt.irqSt[RXF_IRQ_OVF] = s_nxt.irqSt[RXF_IRQ_OVF] | ovfEv;
    s_nxt.irqSt[RXF_IRQ_STUCK] = s_nxt.irqSt[RXF_IRQ_STUCK] | stuckEv;
    s_nxt.irqSt[RXF_IRQ_PKT] = s_nxt.irqSt[RXF_IRQ_PKT] | pktEnd;
    s_nxt.irq = |(s_nxt.irqSt & s_nxt.irqMask);
    // Pins follow the new state so they change on the same edge as it.
    for (int i = 0; i < RXF_PINS; i++) begin
      if (s_nxt.sel[i] == RXF_SEL_LOCK) begin
        s_nxt.pins[i] = lockDet;
      end else if (s_nxt.sel[i] == RXF_SEL_PKT_BUSY) begin
        s_nxt.pins[i] = s_nxt.busy;
      end else begin
        s_nxt.pins[i] = 1'b0;
      end
    end
    // Reads; unmapped indices return zero.
    s_nxt.rdReg = '0;
    s_nxt.rdFifo = popFifo;
    if (regReq.rd) begin
      if (regReq.addr == RXF_REG_PKT_CTRL_FIRST) begin
        s_nxt.rdReg = s_r.ctrlFirst;
      end else if (regReq.addr == RXF_REG_PKT_CTRL_SECOND) begin
        s_nxt.rdReg = s_r.ctrlSecond;
      end else if (regReq.addr == RXF_REG_PKT_LEN) begin
        s_nxt.rdReg = s_r.packet_length_reg;
      end else if (regReq.addr == RXF_REG_PIN_CFG0) begin
        s_nxt.rdReg = 8'(s_r.sel[0]);
      end else if (regReq.addr == RXF_REG_PIN_CFG2) begin
        s_nxt.rdReg = 8'(s_r.sel[1]);
      end else if (regReq.addr == RXF_REG_SYNTH_CAL_ONE) begin
        // The top bit is forced low when locked, so 0x3F means unlocked only.
        s_nxt.rdReg = 8'(RXF_CAL_UNLOCKED);
        if (lockDet) begin
          s_nxt.rdReg = 8'(s_r.calOne);
          s_nxt.rdReg[RXF_CAL_LOCK_MSB] = 1'b0;
        end
      end else if (regReq.addr == RXF_REG_SYNTH_CAL_TWO) begin
        s_nxt.rdReg = s_r.calTwo;
      end else if (regReq.addr == RXF_REG_TEST) begin
        s_nxt.rdReg = s_r.testReg;
      end else if (regReq.addr == RXF_REG_OCCUPANCY) begin
        s_nxt.rdReg = 8'(s_r.count);
        s_nxt.rdReg[RXF_OCC_PF_BIT] = s_r.pfValid;
      end else if (regReq.addr == RXF_REG_PKT_STATUS) begin
        s_nxt.rdReg[RXF_PST_PIN0] = s_r.pins[0];
        s_nxt.rdReg[RXF_PST_PIN2] = s_r.pins[1];
      end else if (regReq.addr == RXF_REG_IRQ_STATUS) begin
        s_nxt.rdReg = 8'(s_r.irqSt);
      end else if (regReq.addr == RXF_REG_IRQ_MASK) begin
        s_nxt.rdReg = 8'(s_r.irqMask);
      end else if (regReq.addr == RXF_REG_STATE) begin
        s_nxt.rdReg = 8'(s_r.state);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Storage and outputs
  // ****************************************
  rxf_fifo_mem #(.W(RXF_DW), .DEPTH(DEPTH)) u_mem (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .we(pfMove),
    .waddr(s_r.wrPtr),
    .wdata(s_r.pfData),
    .raddr(s_r.rdPtr),
    .rdata(memQ)
  );

  // Both sources are flops; the select only picks the one read last cycle.
  assign regRdata = s_r.rdFifo ? memQ : s_r.rdReg;
  assign statusPin = s_r.pins;
  assign irq = s_r.irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_ovf_entry: assert property (ovfEv |=> s_r.state == RXF_OVERFLOW && s_r.irqSt[RXF_IRQ_OVF])
    else $error("overflow not entered");
  chk_ovf_hold: assert property (s_r.state == RXF_OVERFLOW && !cmdFlush |=> s_r.state == RXF_OVERFLOW)
    else $error("overflow left without flush");
  chk_ovf_flush: assert property (s_r.state == RXF_OVERFLOW && cmdFlush |=>
    s_r.state == RXF_IDLE && s_r.count == '0 && !s_r.pfValid)
    else $error("flush did not empty fifo");
  chk_pin_ovf: assert property (s_r.state == RXF_OVERFLOW && s_r.sel[0] == RXF_SEL_PKT_BUSY |-> !statusPin[0])
    else $error("busy pin high in overflow");
  chk_stuck_entry: assert property (stuckEv |=> s_r.state == RXF_STUCK && s_r.busy)
    else $error("stuck receive not entered");
  chk_stuck_exit: assert property (s_r.state == RXF_STUCK && !cmdIdle |=> s_r.state == RXF_STUCK)
    else $error("stuck state left without idle");
  chk_lock_pin: assert property (s_r.sel[0] == RXF_SEL_LOCK |-> statusPin[0] == $past(lockDet))
    else $error("lock pin mismatch");
  chk_cal_lock: assert property (regReq.rd && regReq.addr == RXF_REG_SYNTH_CAL_ONE |=>
    (regRdata != 8'(RXF_CAL_UNLOCKED)) == $past(lockDet))
    else $error("calibration read disagrees with lock");
  chk_test_sleep: assert property (s_r.state == RXF_SLEEP |-> s_r.testReg == RXF_TEST_SLEEP)
    else $error("test register kept in sleep");
  chk_fifo_bound: assert property (s_r.count <= CW'(DEPTH))
    else $error("fifo count above depth");
  chk_lock_irq: assert property (lockRise |=> s_r.irqSt[RXF_IRQ_LOCK])
    else $error("lock rise not flagged");

  cov_overflow: cover property (s_r.state == RXF_RX ##1 s_r.state == RXF_OVERFLOW);
  cov_stuck: cover property (s_r.state == RXF_STUCK ##[1:50] s_r.state == RXF_IDLE);
  cov_append: cover property (s_r.stCnt == RXF_STATUS_BYTES);
  cov_lock: cover property (lockRise);
endmodule : rxf_rx_fifo

// ==== test/rxf_host_model.sv ====
// Behavioural model of the controller core on the register port of the receive FIFO block.
// Assumes the block answers a read one cycle after the read strobe and never stalls.
`timescale 1ns/1ps
module rxf_host_model
  import rxf_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output rxf_pkg::rxf_reg_req_type regReq,
  input wire logic [rxf_pkg::RXF_DW-1:0] regRdata
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    regReq = '0;
  end

  // Released lines show the inverse so that a stale address or datum never looks valid.
  task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    regReq <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    regReq <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
  endtask : write_reg

  task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
    @(posedge ref_clk);
    regReq <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    regReq <= '{addr: ~addr, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    #1;
    data = regRdata;
  endtask : read_reg

  // ****************************************
  // Driver routines
  // ****************************************
  // Packet status bits are not trusted for lock; the first calibration register is.
  task automatic check_lock(output logic locked);
    logic [7:0] d;
    read_reg(RXF_REG_SYNTH_CAL_ONE, d);
    locked = (d[5:0] !== RXF_CAL_UNLOCKED);
  endtask : check_lock

  task automatic set_pkt_len(input logic variableLen);
    write_reg(RXF_REG_PKT_LEN, variableLen ? 8'h3D : 8'h3E);
  endtask : set_pkt_len

  // The lock interrupt stays masked over wake-up, since the lock pin may toggle then.
  task automatic wake();
    logic [7:0] m;
    read_reg(RXF_REG_IRQ_MASK, m);
    write_reg(RXF_REG_IRQ_MASK, m & 8'hFE);
    write_reg(RXF_REG_COMMAND, 8'h01);
    write_reg(RXF_REG_IRQ_STATUS, 8'h01);
    write_reg(RXF_REG_TEST, RXF_TEST_RST);
    write_reg(RXF_REG_IRQ_MASK, m);
  endtask : wake

  task automatic recover();
    write_reg(RXF_REG_COMMAND, 8'h01);
    write_reg(RXF_REG_COMMAND, 8'h04);
  endtask : recover
endmodule : rxf_host_model

// ==== test/radio_rx_fifo_and_lock_status_tb.sv ====
// Self-checking bench of the receive FIFO block: lock status, sleep, packets, overflow.
// Assumes the controller model drives the register port and this module the demodulator.
`timescale 1ns/1ps
module radio_rx_fifo_and_lock_status_tb
  import rxf_pkg::*;
;
  logic ref_clk;
  logic rst_n;
  rxf_reg_req_type regReq;
  logic [RXF_DW-1:0] regRdata;
  rxf_rx_in_type rxIn;
  logic lockDet;
  logic [RXF_PINS-1:0] statusPin;
  logic irq;
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [7:0] expV [6] = '{8'h03, 8'h40, 8'h41, 8'h42, 8'h5A, 8'h11};

  rxf_rx_fifo #(.DEPTH(RXF_DEPTH)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .rxIn(rxIn), .lockDet(lockDet), .statusPin(statusPin), .irq(irq));
  rxf_host_model host (.ref_clk(ref_clk), .regReq(regReq), .regRdata(regRdata));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test();
    if (failures == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [3:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    host.read_reg(addr, d);
    check(d, exp);
  endtask : rd_chk

  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 10) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check({7'h00, irq}, {7'h00, exp});
  endtask : wait_irq

  task automatic wait_occ(input logic [7:0] exp);
    logic [7:0] d;
    int n;
    n = 0;
    host.read_reg(RXF_REG_OCCUPANCY, d);
    while (d !== exp && n < 40) begin
      host.read_reg(RXF_REG_OCCUPANCY, d);
      n++;
    end
    check(d, exp);
  endtask : wait_occ

  // Bytes go back to back; between bursts the data lines carry the inverse of the last byte.
  task automatic send(input int n, input logic [7:0] first);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      rxIn <= '{valid: 1'b1, data: first + 8'(i), rssi: 8'h5A, lqi: 7'h11, crcOk: 1'b1};
    end
    @(posedge ref_clk);
    rxIn <= '{valid: 1'b0, data: ~(first + 8'(n - 1)), rssi: 8'hA5, lqi: 7'h6E, crcOk: 1'b0};
  endtask : send

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // The ceiling is some thirty times the expected run length.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    logic lk;
    rst_n = 1'b0;
    rxIn = '0;
    lockDet = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(RXF_REG_PKT_CTRL_FIRST, 8'h05);
    rd_chk(RXF_REG_PKT_CTRL_SECOND, 8'h04);
    rd_chk(RXF_REG_PKT_LEN, 8'hFF);
    rd_chk(RXF_REG_SYNTH_CAL_TWO, 8'h0A);
    rd_chk(RXF_REG_TEST, 8'h02);
    rd_chk(RXF_REG_STATE, 8'h00);
    rd_chk(4'hF, 8'h00);
    // Lock reporting on the calibration register, the pin and the interrupt.
    rd_chk(RXF_REG_SYNTH_CAL_ONE, 8'h3F);
    host.write_reg(RXF_REG_SYNTH_CAL_ONE, 8'h15);
    host.write_reg(RXF_REG_PIN_CFG0, {2'h0, RXF_SEL_LOCK});
    host.write_reg(RXF_REG_IRQ_MASK, 8'h01);
    @(posedge ref_clk);
    lockDet <= 1'b1;
    #1 check({7'h00, statusPin[0]}, 8'h00);
    @(posedge ref_clk);
    #1 check({7'h00, statusPin[0]}, 8'h01);
    wait_irq(1'b1);
    rd_chk(RXF_REG_IRQ_STATUS, 8'h01);
    rd_chk(RXF_REG_SYNTH_CAL_ONE, 8'h15);
    host.check_lock(lk);
    check({7'h00, lk}, 8'h01);
    host.write_reg(RXF_REG_IRQ_STATUS, 8'h01);
    wait_irq(1'b0);
    host.write_reg(RXF_REG_IRQ_MASK, 8'h00);
    @(posedge ref_clk) lockDet <= 1'b0;
    @(posedge ref_clk) lockDet <= 1'b1;
    rd_chk(RXF_REG_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    // Sleep clears the test register and ignores writes to it.
    host.write_reg(RXF_REG_IRQ_STATUS, 8'hFF);
    host.write_reg(RXF_REG_IRQ_MASK, 8'h01);
    @(posedge ref_clk) lockDet <= 1'b0;
    host.write_reg(RXF_REG_COMMAND, 8'h08);
    @(posedge ref_clk) lockDet <= 1'b1;
    rd_chk(RXF_REG_STATE, 8'h04);
    host.write_reg(RXF_REG_TEST, 8'h06);
    rd_chk(RXF_REG_TEST, 8'h00);
    host.wake();
    rd_chk(RXF_REG_STATE, 8'h00);
    rd_chk(RXF_REG_TEST, 8'h02);
    check({7'h00, irq}, 8'h00);
    // Variable packet with appended status bytes, then a full fixed packet.
    host.write_reg(RXF_REG_PIN_CFG2, {2'h0, RXF_SEL_PKT_BUSY});
    host.write_reg(RXF_REG_IRQ_MASK, 8'h08);
    host.write_reg(RXF_REG_PKT_CTRL_FIRST, 8'h01);
    host.set_pkt_len(1'b1);
    host.write_reg(RXF_REG_COMMAND, 8'h02);
    send(1, 8'h03);
    @(posedge ref_clk);
    #1 check({7'h00, statusPin[1]}, 8'h01);
    send(3, 8'h40);
    wait_occ(8'h06);
    wait_irq(1'b1);
    for (int i = 0; i < 6; i++) begin
      rd_chk(RXF_REG_FIFO_DATA, expV[i]);
    end
    host.write_reg(RXF_REG_PKT_CTRL_FIRST, 8'h00);
    host.write_reg(RXF_REG_PKT_CTRL_SECOND, 8'h00);
    host.set_pkt_len(1'b0);
    host.write_reg(RXF_REG_COMMAND, 8'h01);
    host.write_reg(RXF_REG_COMMAND, 8'h02);
    send(62, 8'h00);
    wait_occ(8'h3E);
    for (int i = 0; i < 62; i++) begin
      rd_chk(RXF_REG_FIFO_DATA, 8'(i));
    end
    // A packet longer than the FIFO is drained while it still arrives.
    host.write_reg(RXF_REG_PKT_LEN, 8'h46);
    host.write_reg(RXF_REG_COMMAND, 8'h01);
    host.write_reg(RXF_REG_COMMAND, 8'h02);
    fork
      send(70, 8'h00);
      begin
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 70; i++) begin
          rd_chk(RXF_REG_FIFO_DATA, 8'(i));
        end
      end
    join
    wait_occ(8'h00);
    // The 66th unread byte overflows; overflow holds until the flush strobe.
    host.write_reg(RXF_REG_PKT_LEN, 8'hFF);
    host.write_reg(RXF_REG_PIN_CFG0, {2'h0, RXF_SEL_PKT_BUSY});
    host.write_reg(RXF_REG_IRQ_STATUS, 8'hFF);
    host.write_reg(RXF_REG_IRQ_MASK, 8'h02);
    host.write_reg(RXF_REG_COMMAND, 8'h01);
    host.write_reg(RXF_REG_COMMAND, 8'h02);
    send(65, 8'h00);
    wait_occ(8'hC0);
    rd_chk(RXF_REG_STATE, 8'h01);
    check({7'h00, statusPin[0]}, 8'h01);
    send(1, 8'h41);
    rd_chk(RXF_REG_STATE, 8'h03);
    check({7'h00, statusPin[0]}, 8'h00);
    wait_irq(1'b1);
    send(4, 8'h50);
    rd_chk(RXF_REG_OCCUPANCY, 8'hC0);
    host.write_reg(RXF_REG_COMMAND, 8'h01);
    rd_chk(RXF_REG_STATE, 8'h03);
    host.write_reg(RXF_REG_COMMAND, 8'h04);
    rd_chk(RXF_REG_STATE, 8'h00);
    rd_chk(RXF_REG_OCCUPANCY, 8'h00);
    // Checksum and append together leave the radio stuck in receive.
    host.write_reg(RXF_REG_PKT_CTRL_FIRST, 8'h04);
    host.write_reg(RXF_REG_PKT_CTRL_SECOND, 8'h04);
    host.write_reg(RXF_REG_IRQ_STATUS, 8'hFF);
    host.write_reg(RXF_REG_COMMAND, 8'h02);
    send(66, 8'h00);
    rd_chk(RXF_REG_STATE, 8'h02);
    check({7'h00, statusPin[0]}, 8'h01);
    rd_chk(RXF_REG_PKT_STATUS, 8'h05);
    rd_chk(RXF_REG_IRQ_STATUS, 8'h04);
    host.write_reg(RXF_REG_COMMAND, 8'h04);
    rd_chk(RXF_REG_STATE, 8'h02);
    host.recover();
    rd_chk(RXF_REG_STATE, 8'h00);
    rd_chk(RXF_REG_OCCUPANCY, 8'h00);
    stop_test();
  end
endmodule : radio_rx_fifo_and_lock_status_tb
